// [src/spss_pkg.sv]
package spss_pkg;
	// ==========================================
	// Register offsets (word indices on the register port)
	localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
	localparam logic [7:0] ADDR_CTRL_TWO = 8'h01;
	localparam logic [7:0] ADDR_TUNING = 8'h04;
	localparam logic [7:0] ADDR_DENOM = 8'h05;
	localparam logic [7:0] ADDR_NUMER = 8'h06;
	localparam logic [7:0] ADDR_RISE_STEP = 8'h07;
	localparam logic [7:0] ADDR_FALL_STEP = 8'h08;
	localparam logic [7:0] ADDR_RAMP_RATE = 8'h09;
	localparam logic [7:0] ADDR_KEY_SCALE = 8'h0A;
	localparam logic [7:0] ADDR_PROFILE_BASE = 8'h0B;
	localparam logic [7:0] ADDR_PROFILE_LAST = 8'h1A;
	localparam logic [7:0] ADDR_SWEEP_STAT = 8'h1B;
	localparam logic [7:0] ADDR_MOD_STAT = 8'h1C;

	// ==========================================
	// Control field positions
	localparam int BIT_KEY_EN = 8;
	localparam int BIT_KEY_MANUAL = 9;
	localparam int BIT_CLK_INV = 10;
	localparam int BIT_CLK_OUT_EN = 11;
	localparam int BIT_MOD_EN = 18;
	localparam int BIT_RAMP_EN = 19;
	localparam int BIT_RAMP_TGT_LO = 20;
	localparam int BIT_PORT_EN = 22;
	localparam int BIT_PROFILE_EN = 23;

	// ==========================================
	// Reset values
	localparam logic [31:0] RST_CTRL_ONE = 32'h0000_0000;
	localparam logic [31:0] RST_CTRL_TWO = 32'h0000_0800;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [11:0] AMP_FULL = 12'hfff;

	// ==========================================
	// Parameter clock: sample clock divided by 24, high one third
	localparam int PCLK_DIV = 24;
	localparam int PCLK_HIGH = PCLK_DIV / 3;
	localparam logic [4:0] PCLK_LAST = 5'(PCLK_DIV - 1);
	localparam logic [4:0] PCLK_HIGH_CNT = 5'(PCLK_HIGH);

	// ==========================================
	// Widths, FIFO depth and profile count
	localparam int PHASE_W = 16;
	localparam int AMP_W = 12;
	localparam int PORT_W = 36;
	localparam int FIFO_DEPTH = 4;
	localparam int PROFILES = 8;

	typedef enum logic [1:0] {
		TGT_FREQ = 2'b00,
		TGT_PHASE = 2'b01,
		TGT_AMP = 2'b10,
		TGT_NONE = 2'b11
	} spss_target_type;

	typedef enum logic [1:0] {
		MAP_FREQ = 2'b00,
		MAP_PHASE = 2'b01,
		MAP_AMP = 2'b10,
		MAP_POLAR = 2'b11
	} spss_map_type;
endpackage : spss_pkg

// [src/spss_source_select.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Small FIFO between port capture and parameter use
module spss_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} spss_fifo_state_type;

	spss_fifo_state_type s_q, s_d;
	logic push;
	logic pop;

	always_comb
	begin
		s_d = s_q;
		in_ready = (s_q.count != (AW+1)'(DEPTH));
		out_valid = (s_q.count != '0);
		out_data = s_q.mem[s_q.rd];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push)
		begin
			s_d.mem[s_q.wr] = in_data;
			s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + AW'(1);
		end
		if (pop)
			s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + AW'(1);
		if (push && !pop)
			s_d.count = s_q.count + (AW+1)'(1);
		else if (pop && !push)
			s_d.count = s_q.count - (AW+1)'(1);
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule : spss_fifo

// ==========================================
// Parameter source selection
module spss_source_select (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_we,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_re,
	output logic [31:0] reg_rdata,
	// Control pins
	input wire logic [2:0] profile_select_pins,
	input wire logic ramp_direction_pin,
	input wire logic ramp_pause_pin,
	input wire logic amplitude_keying,
	// Parallel port
	input wire logic [31:0] port_data,
	input wire logic [3:0] port_function,
	output logic port_ready,
	input wire logic port_apply_hold,
	// Parameter clock
	output logic param_clk_out,
	output logic param_tick,
	// Synthesizer control words
	output logic [31:0] freq_word,
	output logic [15:0] phase_word,
	output logic [11:0] amp_word,
	output logic phase_extra_lsb
);
	typedef struct packed {
		logic [31:0] ctrl_one;
		logic [31:0] ctrl_two;
		logic [31:0] tuning;
		logic [31:0] denom;
		logic [31:0] numer;
		logic [31:0] rise_step;
		logic [31:0] fall_step;
		logic [31:0] ramp_rate;
		logic [11:0] key_scale;
		logic [spss_pkg::PROFILES-1:0][31:0] prof_freq;
		logic [spss_pkg::PROFILES-1:0][31:0] prof_pa;
		logic [4:0] div_cnt;
		logic clk_pin;
		logic tick;
		logic [2:0] prof_sel;
		logic dir_up;
		logic pause;
		logic [31:0] sweep;
		logic [15:0] rate_cnt;
		logic [31:0] mod_acc;
		logic extra;
		logic port_valid;
		logic [35:0] port_word;
		logic [31:0] freq;
		logic [15:0] phase;
		logic [11:0] amp;
		logic [31:0] rdata;
	} spss_state_type;

	spss_state_type s_q, s_d;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [35:0] fifo_out;
	logic capture;
	logic [32:0] mod_sum;
	logic [3:0] pidx;
	logic [2:0] psel;
	logic [31:0] p_freq;
	logic [15:0] p_phase;
	logic [11:0] p_amp;
	logic [1:0] map;
	logic mod_on;
	logic ramp_on;
	logic [1:0] ramp_tgt;
	logic port_on;

	assign capture = s_q.tick && s_q.ctrl_two[spss_pkg::BIT_PORT_EN];
	assign fifo_pop = s_q.tick && !port_apply_hold;

	spss_fifo #(
		.WIDTH(spss_pkg::PORT_W),
		.DEPTH(spss_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rstn(rstn),
		.in_valid(capture),
		.in_ready(fifo_in_ready),
		.in_data({port_function, port_data}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out)
	);

	assign port_ready = fifo_in_ready;
	assign param_clk_out = s_q.clk_pin;
	assign param_tick = s_q.tick;
	assign freq_word = s_q.freq;
	assign phase_word = s_q.phase;
	assign amp_word = s_q.amp;
	assign phase_extra_lsb = s_q.extra;
	assign reg_rdata = s_q.rdata;

	always_comb
	begin
		s_d = s_q;
		pidx = '0;
		mod_sum = '0;

		// ==========================================
		// Register writes
		if (reg_we)
		begin
			unique case (reg_addr)
				spss_pkg::ADDR_CTRL_ONE: s_d.ctrl_one = reg_wdata;
				spss_pkg::ADDR_CTRL_TWO: s_d.ctrl_two = reg_wdata;
				spss_pkg::ADDR_TUNING: s_d.tuning = reg_wdata;
				spss_pkg::ADDR_DENOM: s_d.denom = reg_wdata;
				spss_pkg::ADDR_NUMER: s_d.numer = reg_wdata;
				spss_pkg::ADDR_RISE_STEP: s_d.rise_step = reg_wdata;
				spss_pkg::ADDR_FALL_STEP: s_d.fall_step = reg_wdata;
				spss_pkg::ADDR_RAMP_RATE: s_d.ramp_rate = reg_wdata;
				spss_pkg::ADDR_KEY_SCALE: s_d.key_scale = reg_wdata[spss_pkg::AMP_W-1:0];
				default:
				begin
					if (reg_addr >= spss_pkg::ADDR_PROFILE_BASE && reg_addr <= spss_pkg::ADDR_PROFILE_LAST)
					begin
						pidx = 4'(reg_addr - spss_pkg::ADDR_PROFILE_BASE);
						if (pidx[0])
							s_d.prof_pa[pidx[3:1]] = reg_wdata;
						else
							s_d.prof_freq[pidx[3:1]] = reg_wdata;
					end
				end
			endcase
		end

		// ==========================================
		// Register reads, one cycle latency
		if (reg_re)
		begin
			unique case (reg_addr)
				spss_pkg::ADDR_CTRL_ONE: s_d.rdata = s_q.ctrl_one;
				spss_pkg::ADDR_CTRL_TWO: s_d.rdata = s_q.ctrl_two;
				spss_pkg::ADDR_TUNING: s_d.rdata = s_q.tuning;
				spss_pkg::ADDR_DENOM: s_d.rdata = s_q.denom;
				spss_pkg::ADDR_NUMER: s_d.rdata = s_q.numer;
				spss_pkg::ADDR_RISE_STEP: s_d.rdata = s_q.rise_step;
				spss_pkg::ADDR_FALL_STEP: s_d.rdata = s_q.fall_step;
				spss_pkg::ADDR_RAMP_RATE: s_d.rdata = s_q.ramp_rate;
				spss_pkg::ADDR_KEY_SCALE: s_d.rdata = {20'h0_0000, s_q.key_scale};
				spss_pkg::ADDR_SWEEP_STAT: s_d.rdata = s_q.sweep;
				spss_pkg::ADDR_MOD_STAT: s_d.rdata = s_q.mod_acc;
				default:
				begin
					s_d.rdata = 32'h0000_0000;
					if (reg_addr >= spss_pkg::ADDR_PROFILE_BASE && reg_addr <= spss_pkg::ADDR_PROFILE_LAST)
					begin
						pidx = 4'(reg_addr - spss_pkg::ADDR_PROFILE_BASE);
						s_d.rdata = pidx[0] ? s_q.prof_pa[pidx[3:1]] : s_q.prof_freq[pidx[3:1]];
					end
				end
			endcase
		end

		// ==========================================
		// Divide by 24, high for first third
		s_d.div_cnt = (s_q.div_cnt == spss_pkg::PCLK_LAST) ? 5'h00 : s_q.div_cnt + 5'h01;
		s_d.tick = (s_d.div_cnt == 5'h00);
		// Drive and optionally invert clock copy
		s_d.clk_pin = s_q.ctrl_two[spss_pkg::BIT_CLK_OUT_EN]
			&& ((s_d.div_cnt < spss_pkg::PCLK_HIGH_CNT) ^ s_q.ctrl_two[spss_pkg::BIT_CLK_INV]);
		s_d.extra = 1'b0;

		mod_on = s_q.ctrl_two[spss_pkg::BIT_MOD_EN];
		ramp_on = s_q.ctrl_two[spss_pkg::BIT_RAMP_EN];
		ramp_tgt = s_q.ctrl_two[spss_pkg::BIT_RAMP_TGT_LO +: 2];
		port_on = s_q.ctrl_two[spss_pkg::BIT_PORT_EN];
		// Selection applies at its sampling tick
		psel = s_q.tick ? profile_select_pins : s_q.prof_sel;
		p_freq = s_q.prof_freq[psel];
		p_phase = s_q.prof_pa[psel][31:16];
		p_amp = s_q.prof_pa[psel][spss_pkg::AMP_W-1:0];
		map = s_q.port_word[33:32];

		if (s_q.tick)
		begin
			s_d.prof_sel = profile_select_pins;
			s_d.dir_up = ramp_direction_pin;
			s_d.pause = ramp_pause_pin;
			if (fifo_out_valid && fifo_pop)
				s_d.port_word = fifo_out;
			s_d.port_valid = s_q.port_valid || (fifo_out_valid && fifo_pop);

			if (mod_on)
			begin
				mod_sum = {1'b0, s_q.mod_acc} + {1'b0, s_q.numer};
				if (mod_sum >= {1'b0, s_q.denom})
				begin
					mod_sum = mod_sum - {1'b0, s_q.denom};
					s_d.extra = 1'b1;
				end
				s_d.mod_acc = mod_sum[31:0];
			end
			else
				s_d.mod_acc = '0;

			if (ramp_on && !s_q.pause)
			begin
				if (s_q.rate_cnt != 16'h0000)
					s_d.rate_cnt = s_q.rate_cnt - 16'h0001;
				else if (s_q.dir_up)
				begin
					s_d.sweep = s_q.sweep + s_q.rise_step;
					s_d.rate_cnt = s_q.ramp_rate[15:0];
				end
				else
				begin
					s_d.sweep = s_q.sweep - s_q.fall_step;
					s_d.rate_cnt = s_q.ramp_rate[31:16];
				end
			end

			// ==========================================
			// Profile is the default source
			s_d.freq = p_freq;
			s_d.phase = p_phase;
			s_d.amp = spss_pkg::AMP_FULL;
			if (s_q.ctrl_one[spss_pkg::BIT_KEY_EN])
				// Profile amplitude gated by keying enable
				s_d.amp = p_amp;

			// Port word unsigned, mapped by function pins
			if (port_on && !s_q.ctrl_two[spss_pkg::BIT_PROFILE_EN] && s_q.port_valid)
			begin
				unique case (map)
					spss_pkg::MAP_FREQ: s_d.freq = s_q.port_word[31:0];
					spss_pkg::MAP_PHASE: s_d.phase = s_q.port_word[15:0];
					spss_pkg::MAP_AMP:
						if (s_q.ctrl_one[spss_pkg::BIT_KEY_EN])
							s_d.amp = s_q.port_word[11:0];
					spss_pkg::MAP_POLAR:
					begin
						s_d.phase = s_q.port_word[31:16];
						if (s_q.ctrl_one[spss_pkg::BIT_KEY_EN])
							s_d.amp = s_q.port_word[11:0];
					end
				endcase
			end

			if (ramp_on)
			begin
				unique case (ramp_tgt)
					spss_pkg::TGT_FREQ: s_d.freq = s_q.sweep;
					// Low 16 bits, not under modulus
					spss_pkg::TGT_PHASE:
						if (!mod_on)
							s_d.phase = s_q.sweep[15:0];
					// Low 12 bits, keying enable needed
					spss_pkg::TGT_AMP:
						if (!mod_on && s_q.ctrl_one[spss_pkg::BIT_KEY_EN])
							s_d.amp = s_q.sweep[11:0];
					spss_pkg::TGT_NONE: s_d.freq = s_d.freq;
				endcase
			end

			if (mod_on)
				s_d.freq = s_q.tuning;

			if (s_q.ctrl_one[spss_pkg::BIT_KEY_EN] && s_q.ctrl_one[spss_pkg::BIT_KEY_MANUAL])
				s_d.amp = amplitude_keying ? s_q.key_scale : 12'h000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			s_q <= '0;
			s_q.ctrl_one <= spss_pkg::RST_CTRL_ONE;
			s_q.ctrl_two <= spss_pkg::RST_CTRL_TWO;
			s_q.tuning <= spss_pkg::RST_WORD;
			s_q.amp <= spss_pkg::AMP_FULL;
		end
		else
			s_q <= s_d;
	end
endmodule : spss_source_select

`default_nettype wire

// [testbench/spss_ext_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// ======
// External logic feeding the parallel port
module spss_ext_ctrl (
	// Clock and command
	input wire logic clk,
	input wire logic load,
	input wire logic stay,
	input wire logic [35:0] word,
	// Device side
	input wire logic param_clk_out,
	output logic [31:0] port_data,
	output logic [3:0] port_function
);
	logic [35:0] held_q = 36'h0_0000_0000;
	logic [1:0] left_q = 2'd0;
	logic clk_out_q = 1'b0;
	// word held across two capture edges
	always @(posedge clk)
	begin
		clk_out_q <= param_clk_out;
		if (load)
			left_q <= 2'd2;
		else if (param_clk_out && !clk_out_q && left_q != 2'd0 && !stay)
			left_q <= left_q - 2'd1;
		if (load)
			held_q <= word;
	end
	// Released lines show the inverse of the last word
	assign {port_function, port_data} = (left_q != 2'd0) ? held_q : ~held_q;
endmodule : spss_ext_ctrl
`default_nettype wire

// [testbench/spss_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ======
// Port checker
module spss_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Observed ports
	input wire logic reg_re,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_rdata,
	input wire logic port_ready,
	input wire logic port_apply_hold,
	input wire logic param_tick,
	input wire logic [31:0] freq_word,
	input wire logic [15:0] phase_word,
	input wire logic [11:0] amp_word,
	input wire logic phase_extra_lsb
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_tick_period: assert property (param_tick |-> ##24 param_tick)
		else $error("tick period wrong");
	a_tick_single: assert property (param_tick |=> !param_tick [*8])
		else $error("tick longer than one cycle");
	a_words_hold: assert property (!$past(param_tick) |-> $stable({freq_word, phase_word, amp_word}))
		else $error("control word changed off tick");
	a_lsb_after_tick: assert property (phase_extra_lsb |-> $past(param_tick))
		else $error("extra lsb not after tick");
	a_lsb_pulse: assert property (phase_extra_lsb |=> !phase_extra_lsb)
		else $error("extra lsb too long");
	a_rdata_hold: assert property (!$past(reg_re) |-> $stable(reg_rdata))
		else $error("read data changed without read");
	a_full_holds: assert property (port_apply_hold && !port_ready |=> !port_ready)
		else $error("full buffer drained while held");
	a_unmapped_zero: assert property (reg_re && reg_addr == 8'hff |=> reg_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	c_tick: cover property (param_tick);
	c_wrap: cover property (phase_extra_lsb);
	c_full: cover property (!port_ready);
endmodule : spss_props

bind spss_source_select spss_props u_props (.clk, .rstn, .reg_re, .reg_addr, .reg_rdata, .port_ready,
	.port_apply_hold, .param_tick, .freq_word, .phase_word, .amp_word, .phase_extra_lsb);
`default_nettype wire

// [testbench/spss_source_select_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ======
// Bench
module spss_source_select_tb;
	logic clk, rstn, reg_we, reg_re, ramp_direction_pin, ramp_pause_pin, amplitude_keying;
	logic port_ready, port_apply_hold, param_clk_out, param_tick, phase_extra_lsb, load, stay;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, port_data, freq_word;
	logic [2:0] profile_select_pins;
	logic [3:0] port_function;
	logic [15:0] phase_word;
	logic [11:0] amp_word;
	logic [35:0] word;
	int miscompares = 0;
	int samples_checked = 0;

	spss_source_select dut (.clk, .rstn, .reg_addr, .reg_we, .reg_wdata, .reg_re, .reg_rdata,
		.profile_select_pins, .ramp_direction_pin, .ramp_pause_pin, .amplitude_keying, .port_data,
		.port_function, .port_ready, .port_apply_hold, .param_clk_out, .param_tick, .freq_word,
		.phase_word, .amp_word, .phase_extra_lsb);
	spss_ext_ctrl partner (.clk, .load, .stay, .word, .param_clk_out, .port_data, .port_function);

	always #12.5 clk = ~clk;

	task wrap_up;
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_we = 1'b1;
		@(negedge clk);
		reg_we = 1'b0;
		// Idle cycle so a following write never re-raises the strobe in one step
		@(negedge clk);
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr = a;
		reg_re = 1'b1;
		@(negedge clk);
		reg_re = 1'b0;
		d = reg_rdata;
		@(negedge clk);
	endtask : rd

	// Returns one cycle after the n-th tick, once outputs have moved
	task tk(input int n);
		repeat (n)
		begin
			@(negedge clk);
			while (param_tick !== 1'b1) @(negedge clk);
		end
		@(negedge clk);
	endtask : tk

	task send(input logic [35:0] w);
		word = w;
		load = 1'b1;
		@(negedge clk);
		load = 1'b0;
	endtask : send

	function automatic logic [31:0] pick(input int t);
		return t == 0 ? freq_word : (t == 1 ? {16'h0000, phase_word} : {20'h0_0000, amp_word});
	endfunction : pick

	task t_regs;
		logic [31:0] v;
		rd(8'h01, v);
		chk(v, spss_pkg::RST_CTRL_TWO);
		rd(8'h00, v);
		chk(v, spss_pkg::RST_CTRL_ONE);
		wr(8'h05, 32'h0000_0005);
		rd(8'h05, v);
		chk(v, 32'h0000_0005);
		rd(8'hff, v);
		chk(v, 32'h0000_0000);
	endtask : t_regs

	task cnt_high(output logic [31:0] h);
		repeat (24) @(negedge clk);
		h = 32'h0000_0000;
		repeat (24)
		begin
			@(negedge clk);
			h = h + 32'(param_clk_out);
		end
	endtask : cnt_high

	task t_clkout;
		logic [31:0] h;
		cnt_high(h);
		chk(h, 32'h0000_0008);
		wr(8'h01, 32'h0000_0c00);
		cnt_high(h);
		chk(h, 32'h0000_0010);
		wr(8'h01, 32'h0000_0000);
		cnt_high(h);
		chk(h, 32'h0000_0000);
		wr(8'h01, 32'h0000_0800);
	endtask : t_clkout

	task t_profile;
		wr(8'h11, 32'h1234_5678);
		wr(8'h12, 32'h5555_0abc);
		stay = 1'b1;
		send({4'h0, 32'hdead_beef});
		wr(8'h01, 32'h00c0_0800);
		profile_select_pins = 3'd3;
		tk(3);
		chk(freq_word, 32'h1234_5678);
		chk(phase_word, 32'h0000_5555);
		chk(amp_word, 32'h0000_0fff);
		wr(8'h00, 32'h0000_0100);
		tk(2);
		chk(amp_word, 32'h0000_0abc);
		stay = 1'b0;
		profile_select_pins = 3'd0;
		tk(3);
		chk(freq_word, 32'h0000_0000);
	endtask : t_profile

	task t_keying;
		wr(8'h0a, 32'h0000_0321);
		wr(8'h00, 32'h0000_0300);
		// Profile 3 has a nonzero amplitude that keying must hide
		profile_select_pins = 3'd3;
		amplitude_keying = 1'b1;
		tk(3);
		chk(amp_word, 32'h0000_0321);
		amplitude_keying = 1'b0;
		tk(3);
		chk(amp_word, 32'h0000_0000);
	endtask : t_keying

	task t_ramp;
		logic [31:0] a;
		logic [31:0] m;
		wr(8'h00, 32'h0000_0100);
		// Upper bits zero so every target sees the same step
		wr(8'h07, 32'h0000_0003);
		wr(8'h08, 32'h0000_0001);
		wr(8'h09, 32'h0000_0000);
		for (int t = 0; t < 3; t++)
		begin
			m = t == 0 ? 32'hffff_ffff : (t == 1 ? 32'h0000_ffff : 32'h0000_0fff);
			wr(8'h01, 32'h0008_0800 | (32'(t) << 20));
			ramp_direction_pin = 1'b1;
			tk(3);
			a = pick(t);
			tk(1);
			chk((pick(t) - a) & m, 32'h0000_0003);
			ramp_direction_pin = 1'b0;
			tk(3);
			a = pick(t);
			tk(1);
			chk((a - pick(t)) & m, 32'h0000_0001);
			ramp_pause_pin = 1'b1;
			tk(3);
			a = pick(t);
			tk(1);
			chk(pick(t), a);
			ramp_pause_pin = 1'b0;
		end
		// Amplitude ramp is ignored without the keying enable bit
		wr(8'h00, 32'h0000_0000);
		tk(2);
		chk(amp_word, {20'h0_0000, spss_pkg::AMP_FULL});
		wr(8'h00, 32'h0000_0100);
		// Ramp with no target leaves the profile frequency in place
		wr(8'h01, 32'h0038_0800);
		tk(2);
		chk(freq_word, 32'h1234_5678);
	endtask : t_ramp

	task t_port;
		wr(8'h01, 32'h0040_0800);
		send({4'h0, 32'hcafe_0123});
		tk(3);
		chk(freq_word, 32'hcafe_0123);
		send({4'h3, 32'h7777_0456});
		tk(3);
		chk(phase_word, 32'h0000_7777);
		chk(amp_word, 32'h0000_0456);
		send({4'h1, 32'h0000_1357});
		tk(3);
		chk(phase_word, 32'h0000_1357);
		send({4'h2, 32'h0000_0246});
		tk(3);
		chk(amp_word, 32'h0000_0246);
		port_apply_hold = 1'b1;
		stay = 1'b1;
		send({4'h0, 32'h0000_0042});
		tk(6);
		chk(port_ready, 1'b0);
		port_apply_hold = 1'b0;
		stay = 1'b0;
		tk(8);
		chk(port_ready, 1'b1);
	endtask : t_port

	task t_modulus;
		logic [31:0] n;
		wr(8'h04, 32'h4ccc_cccc);
		wr(8'h05, 32'h0000_0005);
		wr(8'h06, 32'h0000_0004);
		wr(8'h01, 32'h000c_0800);
		tk(2);
		n = 32'h0000_0000;
		repeat (240)
		begin
			@(negedge clk);
			n = n + 32'(phase_extra_lsb);
		end
		chk(n, 32'h0000_0008);
		chk(freq_word, 32'h4ccc_cccc);
	endtask : t_modulus

	initial
	begin
		#400us;
		miscompares++;
		wrap_up;
	end

	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		{reg_we, reg_re, ramp_direction_pin, ramp_pause_pin, amplitude_keying} = 5'h00;
		{port_apply_hold, load, stay, profile_select_pins} = 6'h00;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		word = 36'h0_0000_0000;
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		t_regs;
		t_clkout;
		t_profile;
		t_keying;
		t_ramp;
		t_port;
		t_modulus;
		wrap_up;
	end
endmodule : spss_source_select_tb
`default_nettype wire
